// file: core/ispc_pkg.sv
package ispc_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_PROG_CONTROL = 8'h00_BF;
    localparam logic [7:0] IDX_FLASH_COMMAND = 8'h00_C7;
    localparam logic [7:0] IDX_ADDR_HIGH = 8'h00_C4;
    localparam logic [7:0] IDX_ADDR_LOW = 8'h00_C5;
    localparam logic [7:0] IDX_DATA_BYTE = 8'h00_C6;
    localparam logic [7:0] IDX_WRITE_UNLOCK = 8'h00_C8;
    localparam logic [7:0] IDX_STATUS = 8'h00_C9;

    localparam logic [7:0] UNLOCK_FIRST = 8'h0087;
    localparam logic [7:0] UNLOCK_SECOND = 8'h0059;

    // Programming control fields
    localparam int PC_ENABLE_BIT = 0;
    localparam int PC_BOOT_SEL_BIT = 1;
    localparam int PC_AUX_RAM_BIT = 4;
    localparam int PC_REBOOT_BIT = 7;
    localparam logic [7:0] PC_RESET = 8'h0000;

    // Flash command fields
    localparam int FC_BANK_BIT = 6;
    localparam int FC_OE_BIT = 5;
    localparam int FC_CE_BIT = 4;
    localparam int FC_OP_LSB = 0;
    localparam logic [7:0] FC_RESET = 8'h0000;
    localparam logic [3:0] OP_READ = 4'h0000;
    localparam logic [3:0] OP_PROGRAM = 4'h0001;
    localparam logic [3:0] OP_ERASE = 4'h0002;

    // Bank sizes in bytes
    localparam int APP_BANK_BYTES = 65536;
    localparam int LOADER_BANK_BYTES = 4096;
    localparam logic [7:0] ERASED_BYTE = 8'h00FF;
    localparam logic [15:0] LOADER_ENTRY = 16'h0000;

    typedef enum logic [1:0] {
        UNL_LOCKED = 2'b00,
        UNL_FIRST_SEEN = 2'b01,
        UNL_OPEN = 2'b11
    } ispc_unlock_type;

    typedef enum logic [1:0] {
        SEQ_WAIT = 2'b00,
        SEQ_BUSY = 2'b01,
        SEQ_DONE = 2'b11
    } ispc_seq_type;

endpackage

// file: core/ispc_flash_banks.sv
`timescale 1ns/1ps
`default_nettype none

module ispc_flash_banks (
    input wire logic sys_clk, // Core clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic op_start, // One-cycle start of an operation
    input wire logic [3:0] op_code, // Operation field
    input wire logic op_bank, // 0 application bank, 1 loader bank
    input wire logic [15:0] op_addr, // Target address
    input wire logic [7:0] op_wdata, // Byte to program
    output logic [7:0] op_rdata, // Byte fetched by a read
    output logic op_busy, // Erase sweep in progress
    output logic op_done, // One-cycle pulse at the end
    input wire logic fetch_bank, // Bank instructions come from
    input wire logic [15:0] fetch_addr, // Instruction address
    output logic [7:0] fetch_data // Instruction byte, one cycle later
);

    logic [7:0] app_mem [0:ispc_pkg::APP_BANK_BYTES-1];
    logic [7:0] ldr_mem [0:ispc_pkg::LOADER_BANK_BYTES-1];
    logic [15:0] sweep_r;
    logic erasing_r;
    logic bank_r;
    logic [15:0] last_addr;

    assign last_addr = bank_r ? 16'(ispc_pkg::LOADER_BANK_BYTES - 1) : 16'hFFFF;
    assign op_busy = erasing_r;

    // Erase sweeps the bank one byte per cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            erasing_r <= 1'b0;
            sweep_r <= 16'h0000;
            bank_r <= 1'b0;
            op_done <= 1'b0;
            op_rdata <= 8'h0000;
        end else begin
            op_done <= 1'b0;
            if (op_start && !erasing_r) begin
                bank_r <= op_bank;
                if (op_code == ispc_pkg::OP_ERASE) begin
                    erasing_r <= 1'b1;
                    sweep_r <= 16'h0000;
                end else begin
                    op_done <= 1'b1;
                    if (op_code == ispc_pkg::OP_READ) begin
                        op_rdata <= op_bank ? ldr_mem[op_addr[11:0]] : app_mem[op_addr];
                    end
                end
            end else if (erasing_r) begin
                sweep_r <= sweep_r + 16'h0001;
                if (sweep_r == last_addr) begin
                    erasing_r <= 1'b0;
                    op_done <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (op_start && !erasing_r && op_code == ispc_pkg::OP_PROGRAM) begin
            if (op_bank) begin
                ldr_mem[op_addr[11:0]] <= op_wdata;
            end else begin
                app_mem[op_addr] <= op_wdata;
            end
        end else if (erasing_r) begin
            if (bank_r) begin
                ldr_mem[sweep_r[11:0]] <= ispc_pkg::ERASED_BYTE;
            end else begin
                app_mem[sweep_r] <= ispc_pkg::ERASED_BYTE;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        fetch_data <= fetch_bank ? ldr_mem[fetch_addr[11:0]] : app_mem[fetch_addr];
    end

endmodule

`default_nettype wire

// file: core/ispc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module ispc_ctrl (
    input wire logic sys_clk, // Core clock, 200 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic hsel, // AHB-Lite slave select
    input wire logic [11:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready in
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    input wire logic core_idle, // Core sits in idle mode
    input wire logic core_wake, // Interrupt wake from idle, one cycle
    input wire logic core_return_from_interrupt, // Return-from-interrupt executed, one cycle
    input wire logic forced_boot_pin, // Forced loader boot strap, asynchronous
    input wire logic [15:0] fetch_addr, // Instruction fetch address
    output logic [7:0] fetch_data, // Instruction byte
    output logic fetch_bank, // 1 while fetching from the loader bank
    output logic isp_mode, // Programming mode active
    output logic pc_clear, // Clear program counter, one cycle
    output logic return_from_interrupt_redirect, // Next return goes to the loader entry
    output logic [15:0] return_from_interrupt_target, // Return address while redirecting
    output logic wake_hold, // Keep the core asleep
    output logic cpu_reboot, // Reboot the CPU, one cycle
    output logic aux_ram_enable // Auxiliary RAM enabled
);

    ispc_pkg::ispc_unlock_type unl_r, unl_nxt;
    ispc_pkg::ispc_seq_type seq_r, seq_nxt;
    logic [7:0] prog_ctl_r, prog_ctl_nxt;
    logic [7:0] cmd_r;
    logic [7:0] addr_hi_r;
    logic [7:0] addr_lo_r;
    logic [7:0] data_r;
    logic cmd_pend_r;
    logic reboot_arm_r;
    logic isp_r;
    logic bank_r;
    logic redirect_r;
    logic pc_clear_r;
    logic reboot_r;
    logic forced_r;
    logic boot_done_r;
    logic strap_s1_r, strap_s2_r;
    logic wr_pend_r;
    logic [7:0] idx_r;
    logic fl_busy, fl_done;
    logic [7:0] fl_rdata;

    // Bus decode
    wire addr_phase = hsel && htrans[1] && hready;
    wire wr_data = wr_pend_r;
    wire [7:0] wbyte = hwdata[7:0];
    wire wr_ctl = wr_data && idx_r == ispc_pkg::IDX_PROG_CONTROL;
    wire wr_cmd = wr_data && idx_r == ispc_pkg::IDX_FLASH_COMMAND;
    wire wr_ahi = wr_data && idx_r == ispc_pkg::IDX_ADDR_HIGH;
    wire wr_alo = wr_data && idx_r == ispc_pkg::IDX_ADDR_LOW;
    wire wr_dat = wr_data && idx_r == ispc_pkg::IDX_DATA_BYTE;
    wire wr_unl = wr_data && idx_r == ispc_pkg::IDX_WRITE_UNLOCK;
    wire ctl_open = unl_r == ispc_pkg::UNL_OPEN;

    // Command decode and legality
    wire [3:0] cmd_op = cmd_r[ispc_pkg::FC_OP_LSB +: 4];
    wire cmd_bank = cmd_r[ispc_pkg::FC_BANK_BIT];
    wire cmd_oe = cmd_r[ispc_pkg::FC_OE_BIT];
    wire cmd_ce = cmd_r[ispc_pkg::FC_CE_BIT];
    wire prog_en = prog_ctl_r[ispc_pkg::PC_ENABLE_BIT];
    wire boot_sel = prog_ctl_r[ispc_pkg::PC_BOOT_SEL_BIT];
    wire op_rd = cmd_op == ispc_pkg::OP_READ;
    wire op_wr = cmd_op == ispc_pkg::OP_PROGRAM || cmd_op == ispc_pkg::OP_ERASE;
    // Writes may only hit the bank the loader is not running from
    wire bank_ok = op_rd || cmd_bank == !boot_sel;
    wire oe_ok = op_rd ? !cmd_oe : cmd_oe;
    wire cmd_valid = (op_rd || op_wr) && oe_ok && !cmd_ce && bank_ok;
    wire op_start = seq_r == ispc_pkg::SEQ_WAIT && cmd_pend_r && core_idle
        && isp_r && prog_en && cmd_valid;
    wire enter_isp = core_wake && prog_en && !isp_r;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign fetch_bank = bank_r;
    assign isp_mode = isp_r;
    assign pc_clear = pc_clear_r;
    assign return_from_interrupt_redirect = redirect_r;
    assign return_from_interrupt_target = ispc_pkg::LOADER_ENTRY;
    assign cpu_reboot = reboot_r;
    assign aux_ram_enable = prog_ctl_r[ispc_pkg::PC_AUX_RAM_BIT];
    assign wake_hold = seq_r != ispc_pkg::SEQ_WAIT || op_start;

    // Read mux of flip-flops; unused bits read zero
    wire [7:0] ctl_view = {forced_r, 2'b00, prog_ctl_r[4], 2'b00, prog_ctl_r[1:0]};
    wire [7:0] stat_view = {4'h0000, cmd_pend_r, seq_r, isp_r};
    wire [7:0] rd_byte =
        idx_r == ispc_pkg::IDX_PROG_CONTROL ? ctl_view :
        idx_r == ispc_pkg::IDX_FLASH_COMMAND ? cmd_r :
        idx_r == ispc_pkg::IDX_ADDR_HIGH ? addr_hi_r :
        idx_r == ispc_pkg::IDX_ADDR_LOW ? addr_lo_r :
        idx_r == ispc_pkg::IDX_DATA_BYTE ? data_r :
        idx_r == ispc_pkg::IDX_STATUS ? stat_view : 8'h0000;
    assign hrdata = {24'h0000_00, rd_byte};

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_pend_r <= 1'b0;
            idx_r <= 8'h0000;
        end else begin
            wr_pend_r <= addr_phase && hwrite;
            if (addr_phase) begin
                idx_r <= haddr[9:2];
            end
        end
    end

    // Unlock sequence
    always_comb begin
        unl_nxt = unl_r;
        if (wr_unl) begin
            if (wbyte == ispc_pkg::UNLOCK_FIRST) begin
                unl_nxt = ispc_pkg::UNL_FIRST_SEEN;
            end else if (wbyte == ispc_pkg::UNLOCK_SECOND && unl_r == ispc_pkg::UNL_FIRST_SEEN) begin
                unl_nxt = ispc_pkg::UNL_OPEN;
            end else begin
                unl_nxt = ispc_pkg::UNL_LOCKED;
            end
        end
    end

    // Control register; bits 3, 2 and reserved bits are not stored
    always_comb begin
        prog_ctl_nxt = prog_ctl_r;
        if (wr_ctl && ctl_open) begin
            prog_ctl_nxt = {wbyte[7], 2'b00, wbyte[4], 2'b00, wbyte[1:0]};
        end
    end

    // Sequencer: waits for idle, runs, then releases the wake
    always_comb begin
        seq_nxt = seq_r;
        case (seq_r)
            ispc_pkg::SEQ_WAIT: begin
                if (op_start) begin
                    seq_nxt = ispc_pkg::SEQ_BUSY;
                end
            end
            ispc_pkg::SEQ_BUSY: begin
                if (fl_done) begin
                    seq_nxt = ispc_pkg::SEQ_DONE;
                end
            end
            ispc_pkg::SEQ_DONE: begin
                seq_nxt = ispc_pkg::SEQ_WAIT;
            end
            default: begin
                seq_nxt = ispc_pkg::SEQ_WAIT;
            end
        endcase
    end

    wire soft_reboot = reboot_arm_r && core_idle;

    always_ff @(posedge sys_clk) begin
        if (srst || soft_reboot) begin
            unl_r <= ispc_pkg::UNL_LOCKED;
            seq_r <= ispc_pkg::SEQ_WAIT;
            prog_ctl_r <= ispc_pkg::PC_RESET;
        end else begin
            unl_r <= unl_nxt;
            seq_r <= seq_nxt;
            prog_ctl_r <= prog_ctl_nxt;
        end
    end

    // Software-visible flash registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cmd_r <= ispc_pkg::FC_RESET;
            addr_hi_r <= 8'h0000;
            addr_lo_r <= 8'h0000;
            data_r <= 8'h0000;
        end else begin
            if (wr_cmd) begin
                cmd_r <= wbyte;
            end
            if (wr_ahi) begin
                addr_hi_r <= wbyte;
            end
            if (wr_alo) begin
                addr_lo_r <= wbyte;
            end
            if (fl_done && seq_r == ispc_pkg::SEQ_BUSY && op_rd) begin
                data_r <= fl_rdata;
            end else if (wr_dat) begin
                data_r <= wbyte;
            end
        end
    end

    // Command pending: a new command write wins over the clear at start
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cmd_pend_r <= 1'b0;
        end else if (wr_cmd) begin
            cmd_pend_r <= 1'b1;
        end else if (op_start) begin
            cmd_pend_r <= 1'b0;
        end
    end

    // Mode, bank and reboot control
    always_ff @(posedge sys_clk) begin
        if (srst || soft_reboot) begin
            isp_r <= 1'b0;
            bank_r <= 1'b0;
            redirect_r <= 1'b0;
            pc_clear_r <= 1'b0;
            reboot_arm_r <= 1'b0;
        end else begin
            pc_clear_r <= 1'b0;
            if (!boot_done_r && strap_s2_r) begin
                bank_r <= 1'b1;
            end
            if (enter_isp) begin
                isp_r <= 1'b1;
                // Only a real bank change moves the PC to the loader entry
                if (boot_sel && !bank_r) begin
                    bank_r <= 1'b1;
                    pc_clear_r <= 1'b1;
                    redirect_r <= 1'b1;
                end
            end else if (core_return_from_interrupt) begin
                redirect_r <= 1'b0;
            end
            if (wr_ctl && ctl_open && wbyte[7] && wbyte[1] && wbyte[0]) begin
                reboot_arm_r <= 1'b1;
            end
        end
    end

    // Strap: two flops, then caught once in the first cycle after reset
    always_ff @(posedge sys_clk) begin
        strap_s1_r <= forced_boot_pin;
        strap_s2_r <= strap_s1_r;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            boot_done_r <= 1'b0;
            forced_r <= 1'b0;
            reboot_r <= 1'b0;
        end else begin
            reboot_r <= soft_reboot;
            if (soft_reboot) begin
                forced_r <= 1'b0;
            end else if (!boot_done_r) begin
                boot_done_r <= 1'b1;
                forced_r <= strap_s2_r;
            end
        end
    end

    ispc_flash_banks u_banks (
        .sys_clk(sys_clk),
        .srst(srst),
        .op_start(op_start),
        .op_code(cmd_op),
        .op_bank(cmd_bank),
        .op_addr({addr_hi_r, addr_lo_r}),
        .op_wdata(data_r),
        .op_rdata(fl_rdata),
        .op_busy(fl_busy),
        .op_done(fl_done),
        .fetch_bank(bank_r),
        .fetch_addr(fetch_addr),
        .fetch_data(fetch_data)
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Erase length is counted in logic; a delay that long would choke the property engine
    logic [16:0] sweep_cnt_r;
    wire [16:0] erase_len = cmd_bank ? 17'(ispc_pkg::LOADER_BANK_BYTES)
        : 17'(ispc_pkg::APP_BANK_BYTES);

    always_ff @(posedge sys_clk) begin
        if (srst || op_start) begin
            sweep_cnt_r <= 17'h0_0000;
        end else if (fl_busy) begin
            sweep_cnt_r <= sweep_cnt_r + 17'h0_0001;
        end
    end

    // Two unlock writes with the bus's idle cycles between them
    sequence s_unlock_pair;
        wr_unl && wbyte == ispc_pkg::UNLOCK_FIRST ##1 (!wr_unl)[*2]
        ##1 wr_unl && wbyte == ispc_pkg::UNLOCK_SECOND;
    endsequence

    a_locked_ctl_hold: assert property (
        wr_ctl && !ctl_open && !soft_reboot |=> $stable(prog_ctl_r))
        else $error("control register changed while locked");

    a_unlock_opens: assert property (
        s_unlock_pair |=> ctl_open)
        else $error("unlock pair did not open control access");

    a_bad_value_locks: assert property (
        wr_unl && wbyte != ispc_pkg::UNLOCK_FIRST && wbyte != ispc_pkg::UNLOCK_SECOND
        |=> unl_r == ispc_pkg::UNL_LOCKED)
        else $error("foreign unlock value left access open");

    a_start_in_idle: assert property (
        op_start |-> core_idle && isp_r)
        else $error("flash operation started outside idle");

    a_disabled_no_op: assert property (
        !prog_en |-> !op_start)
        else $error("flash operation while programming disabled");

    a_busy_holds_wake: assert property (
        seq_r == ispc_pkg::SEQ_BUSY |-> wake_hold)
        else $error("wake released while operation busy");

    a_switch_clears_pc: assert property (
        enter_isp && boot_sel && !bank_r |=> pc_clear && redirect_r && fetch_bank)
        else $error("bank switch did not clear the program counter");

    a_reboot_pulse: assert property (
        soft_reboot |=> cpu_reboot && !isp_r && !fetch_bank ##1 !cpu_reboot)
        else $error("software reboot pulse wrong");

    a_forced_reads_one: assert property (
        forced_r && idx_r == ispc_pkg::IDX_PROG_CONTROL |-> hrdata[7])
        else $error("forced boot indicator not visible");

    a_illegal_oe_refused: assert property (
        cmd_pend_r && op_rd && cmd_oe |-> !op_start)
        else $error("read with output enable set was started");

    a_erase_completes: assert property (
        fl_done && seq_r == ispc_pkg::SEQ_BUSY && cmd_op == ispc_pkg::OP_ERASE
        |-> sweep_cnt_r == erase_len)
        else $error("bank erase length wrong");

endmodule

`default_nettype wire

// file: tb/ispc_testbench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module testbench;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic core_idle = 1'b0;
    logic core_wake = 1'b0;
    logic core_return_from_interrupt = 1'b0;
    logic forced_boot_pin = 1'b0;
    logic [15:0] fetch_addr = 16'h0000;
    logic [31:0] hrdata;
    logic hreadyout, hresp, fetch_bank, isp_mode, pc_clear, return_from_interrupt_redirect;
    logic wake_hold, cpu_reboot, aux_ram_enable;
    logic [7:0] fetch_data;
    logic [15:0] return_from_interrupt_target;
    logic rd_phase = 1'b0;
    logic [7:0] exp_v;
    logic [7:0] dbyte;
    logic [7:0] exp_q[$];
    int err_count = 0;
    int n_checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    // The single slave's ready is the bus ready
    ispc_ctrl uut (.sys_clk(sys_clk), .srst(srst), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .core_idle(core_idle), .core_wake(core_wake), .core_return_from_interrupt(core_return_from_interrupt),
        .forced_boot_pin(forced_boot_pin), .fetch_addr(fetch_addr),
        .fetch_data(fetch_data), .fetch_bank(fetch_bank), .isp_mode(isp_mode),
        .pc_clear(pc_clear), .return_from_interrupt_redirect(return_from_interrupt_redirect), .return_from_interrupt_target(return_from_interrupt_target),
        .wake_hold(wake_hold), .cpu_reboot(cpu_reboot), .aux_ram_enable(aux_ram_enable));

    task automatic print_verdict();
        $display("Checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic timeout(input string what);
        err_count++;
        $display("[ERR] %s expected done seen timeout", what);
        print_verdict();
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) timeout("hready");
    endtask

    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge sys_clk);
        htrans <= 2'b10;
        haddr <= {2'b00, idx, 2'b00};
        hwrite <= w;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        wait_ready();
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, idx, 8'h00);
    endtask

    // Idle with a command written; a refused command must never raise wake_hold
    task automatic op(input logic [7:0] cmd, input logic run, input int lim);
        int n;
        wr(ispc_pkg::IDX_FLASH_COMMAND, cmd);
        @(posedge sys_clk);
        core_idle <= 1'b1;
        #1 `CHK("wake_hold start", run, wake_hold)
        if (!run) begin
            repeat (4) @(posedge sys_clk);
            #1 `CHK("wake_hold refused", 1'b0, wake_hold)
        end
        n = 0;
        // Stay idle until the operation lets go, as a timed wake would
        while (wake_hold !== 1'b0 && n < lim) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (wake_hold !== 1'b0) timeout("wake_hold");
        @(posedge sys_clk);
        core_idle <= 1'b0;
    endtask

    // Read data is taken at the edge that ends the data phase
    always @(posedge sys_clk) begin
        if (rd_phase) begin
            exp_v = exp_q.pop_front();
            `CHK("hrdata", {24'h00_0000, exp_v}, hrdata)
        end
        rd_phase <= htrans[1] && !hwrite && hreadyout;
    end

    initial begin
        int n;
        void'($urandom(32'he8a4));
        dbyte = 8'($urandom());
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        #1 `CHK("hreadyout", 1'b1, hreadyout)
        `CHK("hresp", 1'b0, hresp)
        rd(ispc_pkg::IDX_PROG_CONTROL, 8'h00);
        rd(ispc_pkg::IDX_FLASH_COMMAND, 8'h00);
        wr(ispc_pkg::IDX_PROG_CONTROL, 8'h13);
        rd(ispc_pkg::IDX_PROG_CONTROL, 8'h00);
        wr(ispc_pkg::IDX_WRITE_UNLOCK, ispc_pkg::UNLOCK_FIRST);
        wr(ispc_pkg::IDX_WRITE_UNLOCK, ispc_pkg::UNLOCK_SECOND);
        wr(ispc_pkg::IDX_PROG_CONTROL, 8'h11);
        #1 `CHK("aux_ram_enable", 1'b1, aux_ram_enable)
        rd(ispc_pkg::IDX_PROG_CONTROL, 8'h11);
        wr(ispc_pkg::IDX_WRITE_UNLOCK, 8'h00);
        wr(ispc_pkg::IDX_PROG_CONTROL, 8'h00);
        rd(ispc_pkg::IDX_PROG_CONTROL, 8'h11);
        wr(8'h10, 8'h5A);
        rd(8'h10, 8'h00);
        wr(ispc_pkg::IDX_WRITE_UNLOCK, ispc_pkg::UNLOCK_FIRST);
        wr(ispc_pkg::IDX_WRITE_UNLOCK, ispc_pkg::UNLOCK_SECOND);
        wr(ispc_pkg::IDX_PROG_CONTROL, 8'h02);
        #1 `CHK("aux_ram_enable", 1'b0, aux_ram_enable)
        op(8'h00, 1'b0, 1);
        wr(ispc_pkg::IDX_PROG_CONTROL, 8'h03);
        // Wake from idle enters programming mode and switches to the loader bank
        @(posedge sys_clk);
        core_idle <= 1'b1;
        @(posedge sys_clk);
        core_wake <= 1'b1;
        @(posedge sys_clk);
        core_wake <= 1'b0;
        core_idle <= 1'b0;
        #1 `CHK("isp_mode", 1'b1, isp_mode)
        `CHK("fetch_bank", 1'b1, fetch_bank)
        `CHK("pc_clear", 1'b1, pc_clear)
        `CHK("return_from_interrupt_redirect", 1'b1, return_from_interrupt_redirect)
        `CHK("return_from_interrupt_target", 16'h0000, return_from_interrupt_target)
        @(posedge sys_clk);
        core_return_from_interrupt <= 1'b1;
        #1 `CHK("pc_clear", 1'b0, pc_clear)
        @(posedge sys_clk);
        core_return_from_interrupt <= 1'b0;
        #1 `CHK("return_from_interrupt_redirect", 1'b0, return_from_interrupt_redirect)
        wr(ispc_pkg::IDX_ADDR_HIGH, 8'h12);
        wr(ispc_pkg::IDX_ADDR_LOW, 8'h34);
        wr(ispc_pkg::IDX_DATA_BYTE, dbyte);
        // Loader-bank program, program with output enable low, read with it high: refused
        op(8'h61, 1'b0, 1);
        op(8'h01, 1'b0, 1);
        op(8'h20, 1'b0, 1);
        rd(ispc_pkg::IDX_STATUS, 8'h09);
        op(8'h21, 1'b1, 20);
        rd(ispc_pkg::IDX_STATUS, 8'h01);
        wr(ispc_pkg::IDX_DATA_BYTE, ~dbyte);
        op(8'h00, 1'b1, 20);
        rd(ispc_pkg::IDX_DATA_BYTE, dbyte);
        op(8'h22, 1'b1, 70000);
        op(8'h00, 1'b1, 20);
        rd(ispc_pkg::IDX_DATA_BYTE, ispc_pkg::ERASED_BYTE);
        // Software reboot fires on idle entry and returns to normal fetch
        wr(ispc_pkg::IDX_PROG_CONTROL, 8'h83);
        @(posedge sys_clk);
        core_idle <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while (cpu_reboot !== 1'b1 && n < 10);
        `CHK("cpu_reboot", 1'b1, cpu_reboot)
        @(posedge sys_clk);
        core_idle <= 1'b0;
        fetch_addr <= 16'h1234;
        #1 `CHK("isp_mode", 1'b0, isp_mode)
        `CHK("fetch_bank", 1'b0, fetch_bank)
        @(posedge sys_clk);
        #1 `CHK("fetch_data", ispc_pkg::ERASED_BYTE, fetch_data)
        wr(ispc_pkg::IDX_PROG_CONTROL, 8'h10);
        rd(ispc_pkg::IDX_PROG_CONTROL, 8'h00);
        // Second reset with the forced loader strap high
        @(posedge sys_clk);
        forced_boot_pin <= 1'b1;
        srst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd(ispc_pkg::IDX_PROG_CONTROL, 8'h80);
        #1 `CHK("fetch_bank", 1'b1, fetch_bank)
        repeat (2) @(posedge sys_clk);
        print_verdict();
    end
endmodule

`default_nettype wire
